// File: inc/ldu_pkg.sv
// shared constants and types of the load unit
package ldu_pkg;
	// register file layout, 32 words of 32 bits
	localparam int unsigned REG_AW      = 5;
	localparam int unsigned WORD_W      = 32;
	localparam int unsigned ACC_W       = 40;
	localparam int unsigned IMM_W       = 18;
	localparam int unsigned OP_W        = 5;
	localparam int unsigned RD_PORTS    = 4;
	localparam logic [4:0]  PTR_FIRST   = 5'h08;
	localparam logic [4:0]  FRAME_PTR   = 5'h0f;
	localparam logic [4:0]  IDX_FIRST   = 5'h10;
	localparam logic [4:0]  BASE_STEP   = 5'h08;
	localparam logic [4:0]  LEN_STEP    = 5'h0c;
	localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
	localparam logic [39:0] ACC_RESET   = 40'h00_0000_0000;
	localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
	// accumulator clear selection in the destination field
	localparam logic [4:0]  ACC_SEL_FIRST  = 5'h00;
	localparam logic [4:0]  ACC_SEL_SECOND = 5'h01;
	localparam logic [4:0]  ACC_SEL_BOTH   = 5'h02;
	// operation codes on the instruction port
	localparam logic [4:0] OP_LDI_LO   = 5'h00;
	localparam logic [4:0] OP_LDI_HI   = 5'h01;
	localparam logic [4:0] OP_LDI_Z    = 5'h02;
	localparam logic [4:0] OP_LDI_X16  = 5'h03;
	localparam logic [4:0] OP_LDI_X7   = 5'h04;
	localparam logic [4:0] OP_ACC_CLR  = 5'h05;
	localparam logic [4:0] OP_LD_IND   = 5'h06;
	localparam logic [4:0] OP_LD_INC   = 5'h07;
	localparam logic [4:0] OP_LD_DEC   = 5'h08;
	localparam logic [4:0] OP_LD_OFS6  = 5'h09;
	localparam logic [4:0] OP_LD_ADD17 = 5'h0a;
	localparam logic [4:0] OP_LD_SUB17 = 5'h0b;
	localparam logic [4:0] OP_LD_FP    = 5'h0c;
	localparam logic [4:0] OP_LD_PIDX  = 5'h0d;
	localparam logic [4:0] OP_LD_IIND  = 5'h0e;
	localparam logic [4:0] OP_LD_IINC  = 5'h0f;
	localparam logic [4:0] OP_LD_IDEC  = 5'h10;
	localparam logic [4:0] OP_LD_IMOD  = 5'h11;
	// address generator modes
	typedef enum logic [1:0] {
		AG_ADD  = 2'b00,
		AG_SUB  = 2'b01,
		AG_POST = 2'b10,
		AG_CIRC = 2'b11
	} ldu_ag_mode_e;
	// control states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_MEM  = 3'b100
	} ldu_state_e;
endpackage

// File: inc/ldu_ag_if.sv
// operands and results between the unit and its address generator
interface ldu_ag_if;
	ldu_pkg::ldu_ag_mode_e mode;
	logic [31:0]           base;
	logic [31:0]           modv;
	logic [31:0]           ofs;
	logic [31:0]           len;
	logic [31:0]           cbase;
	logic [31:0]           addr;
	logic [31:0]           upd;
	logic                  misalign;
	modport client (output mode, base, modv, ofs, len, cbase,
		input addr, upd, misalign);
	modport unit (input mode, base, modv, ofs, len, cbase,
		output addr, upd, misalign);
endinterface

// File: core/ldu_regfile.sv
// register file: 32 words, registered read ports, two write ports
module ldu_regfile (
	// clock
	input  wire logic        clock_in,
	// reads
	input  wire logic        rd_en_in,
	input  wire logic [19:0] rd_addr_in,
	output logic      [127:0] rd_data_out,
	// writes, port 0 wins on a clash
	input  wire logic        we0_in,
	input  wire logic [4:0]  wa0_in,
	input  wire logic [31:0] wd0_in,
	input  wire logic        we1_in,
	input  wire logic [4:0]  wa1_in,
	input  wire logic [31:0] wd1_in
);
	logic [31:0] mem_q [32];

	// no reset on the array: index, length and base stay unknown
	always_ff @(posedge clock_in) begin
		if (we1_in) begin
			mem_q[wa1_in] <= wd1_in;
		end
		if (we0_in) begin
			mem_q[wa0_in] <= wd0_in;
		end
	end

	// each read port is captured when an instruction is taken
	for (genvar g = 0; g < ldu_pkg::RD_PORTS; g++) begin : g_rd
		always_ff @(posedge clock_in) begin
			if (rd_en_in) begin
				rd_data_out[g*32 +: 32] <= mem_q[rd_addr_in[g*5 +: 5]];
			end
		end
	end
endmodule

// File: core/ldu_addr_gen.sv
// effective address, pointer update and alignment check
module ldu_addr_gen (
	// operands and results
	ldu_ag_if.unit ag
);
	logic [31:0] sum;
	logic [31:0] lim;

	// post forms read at the bare pointer; circular wraps by length
	always_comb begin
		sum = ag.base + ag.modv;
		lim = ag.cbase + ag.len;
		ag.upd = sum;
		case (ag.mode)
			ldu_pkg::AG_ADD: ag.addr = ag.base + ag.ofs;
			ldu_pkg::AG_SUB: ag.addr = ag.base - ag.ofs;
			default: ag.addr = ag.base;
		endcase
		if (ag.mode == ldu_pkg::AG_CIRC && ag.len != '0) begin
			if (!ag.modv[31] && sum >= lim) begin
				ag.upd = sum - ag.len;
			end else if (ag.modv[31] && sum < ag.cbase) begin
				ag.upd = sum + ag.len;
			end
		end
		ag.misalign = ag.addr[1:0] != 2'b00;
	end
endmodule

// File: core/ldu_core.sv
// immediate, pointer and data register load unit
// Function
// - short form sign-extends a 7-bit constant into a data or pointer reg.
// - long signed form writes a 16-bit constant sign-extended to 32 bits.
// - zero-extended form writes a 16-bit constant, upper bits cleared.
// - sign-extended forms copy the constant's top bit into upper bits.
// - half loads write only the chosen half, keeping the other intact.
// - accumulators can only be cleared: first, second or both.
// - offset, post, indirect, frame forms short; big offsets long.
// - pointer load fetches one word addressed from a pointer register.
// - word loads need a 4-byte aligned address, else misalign fault.
// - post forms read at the old pointer, then step it by 4.
// - small offset of 0 to 60 is added without changing the pointer.
// - large offset up to 131068 added or subtracted, pointer kept.
// - frame form subtracts 4 to 128 from the frame pointer.
// - pointer load onto its own stepped pointer is undefined.
// - data load writes a word addressed by pointer, index or frame.
// - index register updates wrap circularly under their length.
// - index, length and base registers are not set by reset.
// - long pointer-load forms may not issue in parallel with others.
// - accumulator clear is accepted when issued in parallel.
// - pointer-index form reads at the first, then adds the second to it unless both are the same register.
module ldu_core (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	// instruction port
	input  wire logic        instr_valid_in,
	output logic             instr_ready_out,
	input  wire logic [4:0]  instr_op_in,
	input  wire logic [4:0]  instr_dst_in,
	input  wire logic [4:0]  instr_src_in,
	input  wire logic [4:0]  instr_idx_in,
	input  wire logic [17:0] instr_imm_in,
	input  wire logic        instr_parallel_in,
	output logic             instr_len32_out,
	// data memory path
	output logic             mem_req_out,
	output logic      [31:0] mem_addr_out,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	// results
	output logic             wb_valid_out,
	output logic      [4:0]  wb_sel_out,
	output logic      [31:0] wb_data_out,
	output logic      [39:0] accum_first_out,
	output logic      [39:0] accum_second_out,
	output logic             exc_misalign_out,
	output logic             exc_undef_out
);
	ldu_pkg::ldu_state_e state_q;
	logic [4:0]   op_q;
	logic [4:0]   dst_q;
	logic [4:0]   src_q;
	logic [4:0]   idx_q;
	logic [17:0]  imm_q;
	logic         par_q;
	logic [127:0] rd_data;
	logic [19:0]  rd_addr;
	logic [31:0]  rd0;
	logic [31:0]  rd1;
	logic         take;
	logic         illegal;
	logic         is_imm;
	logic         is_load;
	logic         upd_en;
	logic [31:0]  imm_val;
	logic         upd_en_q;
	logic [4:0]   upd_sel_q;
	logic [31:0]  upd_val_q;
	logic         we0;
	logic         we1;
	ldu_ag_if     ag ();

	// register classes, used by the legality check
	function automatic logic is_data(input logic [4:0] r);
		return r < ldu_pkg::PTR_FIRST;
	endfunction
	function automatic logic is_ptr(input logic [4:0] r);
		return r >= ldu_pkg::PTR_FIRST && r < ldu_pkg::IDX_FIRST;
	endfunction
	function automatic logic is_ireg(input logic [4:0] r);
		return r >= ldu_pkg::IDX_FIRST && r < 5'h14;
	endfunction
	function automatic logic is_long(input logic [4:0] op);
		return op <= ldu_pkg::OP_ACC_CLR && op != ldu_pkg::OP_LDI_X7
			|| op == ldu_pkg::OP_LD_ADD17 || op == ldu_pkg::OP_LD_SUB17;
	endfunction

	// a new instruction is only taken while idle
	assign instr_ready_out = state_q == ldu_pkg::ST_IDLE;
	assign take = instr_valid_in && instr_ready_out;

	// read ports: pointer or half target, modifier, length, base
	always_comb begin
		rd_addr[4:0] = instr_src_in;
		if (instr_op_in == ldu_pkg::OP_LDI_LO
			|| instr_op_in == ldu_pkg::OP_LDI_HI) begin
			rd_addr[4:0] = instr_dst_in;
		end else if (instr_op_in == ldu_pkg::OP_LD_FP) begin
			rd_addr[4:0] = ldu_pkg::FRAME_PTR;
		end
		rd_addr[9:5]   = instr_idx_in;
		rd_addr[14:10] = instr_src_in + ldu_pkg::LEN_STEP;
		rd_addr[19:15] = instr_src_in + ldu_pkg::BASE_STEP;
	end

	ldu_regfile u_rf (
		.clock_in    (clock_in),
		.rd_en_in    (take),
		.rd_addr_in  (rd_addr),
		.rd_data_out (rd_data),
		.we0_in      (we0),
		.wa0_in      (dst_q),
		.wd0_in      (state_q == ldu_pkg::ST_EXEC ? imm_val : mem_rdata_in),
		.we1_in      (we1),
		.wa1_in      (upd_sel_q),
		.wd1_in      (upd_val_q)
	);

	ldu_addr_gen u_ag (
		.ag (ag.unit)
	);

	assign rd0 = rd_data[31:0];
	assign rd1 = rd_data[63:32];

	// latch the taken instruction
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			op_q  <= '0;
			dst_q <= '0;
			src_q <= '0;
			idx_q <= '0;
			imm_q <= '0;
			par_q <= 1'b0;
			instr_len32_out <= 1'b0;
		end else if (take) begin
			op_q  <= instr_op_in;
			dst_q <= instr_dst_in;
			src_q <= instr_op_in == ldu_pkg::OP_LD_FP ?
				ldu_pkg::FRAME_PTR : instr_src_in;
			idx_q <= instr_idx_in;
			imm_q <= instr_imm_in;
			par_q <= instr_parallel_in;
			instr_len32_out <= is_long(instr_op_in);
		end
	end

	// decode of the latched instruction, evaluated in the execute cycle
	always_comb begin
		illegal  = 1'b0;
		is_imm   = 1'b1;
		is_load  = 1'b0;
		upd_en   = 1'b0;
		imm_val  = WORD_RESET_f();
		ag.mode  = ldu_pkg::AG_ADD;
		ag.base  = rd0;
		ag.modv  = ldu_pkg::WORD_STEP;
		ag.ofs   = '0;
		ag.len   = rd_data[95:64];
		ag.cbase = rd_data[127:96];
		case (op_q)
			ldu_pkg::OP_LDI_LO: begin
				imm_val = {rd0[31:16], imm_q[15:0]};
			end
			ldu_pkg::OP_LDI_HI: begin
				imm_val = {imm_q[15:0], rd0[15:0]};
			end
			ldu_pkg::OP_LDI_Z: begin
				imm_val = {16'h0000, imm_q[15:0]};
			end
			ldu_pkg::OP_LDI_X16: begin
				imm_val = {{16{imm_q[15]}}, imm_q[15:0]};
			end
			ldu_pkg::OP_LDI_X7: begin
				imm_val = {{25{imm_q[6]}}, imm_q[6:0]};
				illegal = !(is_data(dst_q) || is_ptr(dst_q));
			end
			ldu_pkg::OP_ACC_CLR: begin
				illegal = dst_q > ldu_pkg::ACC_SEL_BOTH;
			end
			default: begin
				is_imm  = 1'b0;
				is_load = 1'b1;
				illegal = !(is_data(dst_q) || is_ptr(dst_q));
			end
		endcase
		case (op_q)
			ldu_pkg::OP_LD_IND, ldu_pkg::OP_LD_OFS6: begin
				ag.ofs  = {26'h000_0000, imm_q[5:0]};
				if (op_q == ldu_pkg::OP_LD_IND) begin
					ag.ofs = '0;
				end
				illegal = illegal || !is_ptr(src_q);
			end
			ldu_pkg::OP_LD_INC, ldu_pkg::OP_LD_DEC: begin
				ag.mode = ldu_pkg::AG_POST;
				ag.modv = op_q == ldu_pkg::OP_LD_INC ?
					ldu_pkg::WORD_STEP : -ldu_pkg::WORD_STEP;
				upd_en  = 1'b1;
				illegal = illegal || !is_ptr(src_q)
					|| dst_q == src_q;
			end
			ldu_pkg::OP_LD_ADD17, ldu_pkg::OP_LD_SUB17: begin
				ag.ofs  = {15'h0000, imm_q[16:0]};
				ag.mode = op_q == ldu_pkg::OP_LD_ADD17 ?
					ldu_pkg::AG_ADD : ldu_pkg::AG_SUB;
				illegal = illegal || !is_ptr(src_q);
			end
			ldu_pkg::OP_LD_FP: begin
				ag.ofs  = {24'h00_0000, imm_q[7:0]};
				ag.mode = ldu_pkg::AG_SUB;
			end
			ldu_pkg::OP_LD_PIDX: begin
				ag.mode = ldu_pkg::AG_POST;
				ag.modv = rd1;
				upd_en  = idx_q != src_q;
				illegal = illegal || !is_data(dst_q) || !is_ptr(src_q)
					|| !is_ptr(idx_q);
			end
			ldu_pkg::OP_LD_IIND, ldu_pkg::OP_LD_IINC,
			ldu_pkg::OP_LD_IDEC, ldu_pkg::OP_LD_IMOD: begin
				ag.mode = ldu_pkg::AG_CIRC;
				ag.modv = op_q == ldu_pkg::OP_LD_IDEC ?
					-ldu_pkg::WORD_STEP : ldu_pkg::WORD_STEP;
				if (op_q == ldu_pkg::OP_LD_IMOD) begin
					ag.modv = rd1;
				end
				upd_en  = op_q != ldu_pkg::OP_LD_IIND;
				illegal = illegal || !is_data(dst_q) || !is_ireg(src_q);
			end
			default: begin
				if (is_load) begin
					illegal = 1'b1;
				end
			end
		endcase
		// long forms refuse parallel issue, the accumulator clear does not
		if (par_q && is_long(op_q) && op_q != ldu_pkg::OP_ACC_CLR) begin
			illegal = 1'b1;
		end
	end

	// keeps the decode default free of a bare literal
	function automatic logic [31:0] WORD_RESET_f();
		return ldu_pkg::WORD_RESET;
	endfunction

	// sequencing: idle, execute, wait for the memory answer
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= ldu_pkg::ST_IDLE;
		end else begin
			case (state_q)
				ldu_pkg::ST_IDLE: begin
					if (take) begin
						state_q <= ldu_pkg::ST_EXEC;
					end
				end
				ldu_pkg::ST_EXEC: begin
					if (is_load && !illegal && !ag.misalign) begin
						state_q <= ldu_pkg::ST_MEM;
					end else begin
						state_q <= ldu_pkg::ST_IDLE;
					end
				end
				ldu_pkg::ST_MEM: begin
					if (mem_ack_in) begin
						state_q <= ldu_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= ldu_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// memory request and the deferred pointer update
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mem_req_out  <= 1'b0;
			mem_addr_out <= '0;
			upd_en_q     <= 1'b0;
			upd_sel_q    <= '0;
			upd_val_q    <= '0;
		end else if (state_q == ldu_pkg::ST_EXEC) begin
			// a fault never reaches memory, so nothing is written back
			mem_req_out  <= is_load && !illegal && !ag.misalign;
			mem_addr_out <= ag.addr;
			upd_en_q     <= upd_en;
			upd_sel_q    <= src_q;
			upd_val_q    <= ag.upd;
		end else if (mem_ack_in) begin
			mem_req_out <= 1'b0;
		end
	end

	// register file writes: constant in execute, memory word on answer
	assign we0 = state_q == ldu_pkg::ST_EXEC && is_imm && !illegal
		&& op_q != ldu_pkg::OP_ACC_CLR
		|| state_q == ldu_pkg::ST_MEM && mem_ack_in;
	assign we1 = state_q == ldu_pkg::ST_MEM && mem_ack_in && upd_en_q;

	// write-back report and exception pulses
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wb_valid_out     <= 1'b0;
			wb_sel_out       <= '0;
			wb_data_out      <= '0;
			exc_misalign_out <= 1'b0;
			exc_undef_out    <= 1'b0;
		end else begin
			wb_valid_out     <= we0;
			wb_sel_out       <= dst_q;
			wb_data_out      <= state_q == ldu_pkg::ST_EXEC ?
				imm_val : mem_rdata_in;
			exc_undef_out    <= state_q == ldu_pkg::ST_EXEC && illegal;
			exc_misalign_out <= state_q == ldu_pkg::ST_EXEC && is_load
				&& !illegal && ag.misalign;
		end
	end

	// accumulators: clearing is the only immediate operation
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			accum_first_out  <= ldu_pkg::ACC_RESET;
			accum_second_out <= ldu_pkg::ACC_RESET;
		end else if (state_q == ldu_pkg::ST_EXEC && !illegal
			&& op_q == ldu_pkg::OP_ACC_CLR) begin
			if (dst_q != ldu_pkg::ACC_SEL_SECOND) begin
				accum_first_out <= ldu_pkg::ACC_RESET;
			end
			if (dst_q != ldu_pkg::ACC_SEL_FIRST) begin
				accum_second_out <= ldu_pkg::ACC_RESET;
			end
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_take(logic [4:0] opc);
		take && instr_op_in == opc;
	endsequence

	property p_req_aligned;
		mem_req_out |-> mem_addr_out[1:0] == 2'b00;
	endproperty
	a_req_aligned: assert property (p_req_aligned)
		else $error("request to a misaligned address");

	property p_fault_no_wb;
		exc_undef_out || exc_misalign_out |-> !wb_valid_out && !mem_req_out;
	endproperty
	a_fault_no_wb: assert property (p_fault_no_wb)
		else $error("faulting load still wrote or requested");

	property p_req_hold;
		mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request dropped before its answer");

	property p_ack_wb;
		mem_req_out && mem_ack_in |=>
			wb_valid_out && wb_data_out == $past(mem_rdata_in);
	endproperty
	a_ack_wb: assert property (p_ack_wb)
		else $error("memory word not written back");

	property p_long_par;
		s_take(ldu_pkg::OP_LD_ADD17) && instr_parallel_in |-> ##2 exc_undef_out;
	endproperty
	a_long_par: assert property (p_long_par)
		else $error("long load issued in parallel not refused");

	property p_acc_par;
		s_take(ldu_pkg::OP_ACC_CLR) && instr_dst_in == ldu_pkg::ACC_SEL_BOTH
			|-> ##2 !exc_undef_out && accum_first_out == ldu_pkg::ACC_RESET
			&& accum_second_out == ldu_pkg::ACC_RESET;
	endproperty
	a_acc_par: assert property (p_acc_par)
		else $error("accumulator clear refused or incomplete");

	property p_short_sext;
		s_take(ldu_pkg::OP_LDI_X7) && instr_dst_in < ldu_pkg::IDX_FIRST
			&& !instr_parallel_in |-> ##2 wb_valid_out
			&& wb_data_out == {{25{$past(instr_imm_in[6], 2)}},
			$past(instr_imm_in[6:0], 2)};
	endproperty
	a_short_sext: assert property (p_short_sext)
		else $error("short constant not sign-extended");

	property p_zext;
		s_take(ldu_pkg::OP_LDI_Z) && !instr_parallel_in
			|-> ##2 wb_valid_out && wb_data_out[31:16] == 16'h0000;
	endproperty
	a_zext: assert property (p_zext)
		else $error("zero-extended constant has upper bits set");

	property p_self_step;
		s_take(ldu_pkg::OP_LD_INC) && instr_dst_in == instr_src_in
			|-> ##2 exc_undef_out;
	endproperty
	a_self_step: assert property (p_self_step)
		else $error("load onto its own stepped pointer accepted");
endmodule

// File: dv/ldu_mem_model.sv
// data memory responder standing on the far side of the load unit
module ldu_mem_model (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	// answer delay in cycles, 0 answers at once
	input  wire logic [1:0]  lat_in,
	// memory path
	input  wire logic        mem_req_in,
	input  wire logic [31:0] mem_addr_in,
	output logic             mem_ack_out,
	output logic      [31:0] mem_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_q;
	logic       open_w;
	// a request counts as open until its single ack pulse
	assign open_w = mem_req_in && !mem_ack_out;
	// data flips every cycle outside the ack so a late sample is caught
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mem_ack_out   <= 1'b0;
			mem_rdata_out <= 32'hffff_ffff;
			wait_q        <= 2'h0;
		end else if (open_w && wait_q >= lat_in) begin
			mem_ack_out   <= 1'b1;
			mem_rdata_out <= {~mem_addr_in[15:0], mem_addr_in[15:0]};
			wait_q        <= 2'h0;
		end else begin
			mem_ack_out   <= 1'b0;
			mem_rdata_out <= ~mem_rdata_out;
			wait_q        <= open_w ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule

// File: dv/tb_top.sv
// self-checking bench of the load unit with a memory responder
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_in, reset_n_in, instr_valid_in, instr_parallel_in;
	logic [4:0]  instr_op_in, instr_dst_in, instr_src_in, instr_idx_in;
	logic [17:0] instr_imm_in;
	logic [1:0]  lat;
	logic        instr_ready_out, instr_len32_out, mem_req_out, mem_ack_in;
	logic        wb_valid_out, exc_misalign_out, exc_undef_out;
	logic [31:0] mem_addr_out, mem_rdata_in, wb_data_out;
	logic [4:0]  wb_sel_out;
	logic [39:0] accum_first_out, accum_second_out;
	logic        g_len, g_req, g_wb, g_mis, g_und;
	logic [31:0] g_addr, g_data;
	logic [4:0]  g_sel;
	int          n_fail, tests_run;

	ldu_core uut (.clock_in, .reset_n_in, .instr_valid_in,
		.instr_ready_out, .instr_op_in, .instr_dst_in, .instr_src_in,
		.instr_idx_in, .instr_imm_in, .instr_parallel_in,
		.instr_len32_out, .mem_req_out, .mem_addr_out, .mem_ack_in,
		.mem_rdata_in, .wb_valid_out, .wb_sel_out, .wb_data_out,
		.accum_first_out, .accum_second_out, .exc_misalign_out,
		.exc_undef_out);
	ldu_mem_model mem (.clock_in, .reset_n_in, .lat_in(lat),
		.mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out),
		.mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

	// 50 MHz
	always #10 clock_in = ~clock_in;

	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
		end
	endtask

	// memory contents as the responder builds them
	function automatic logic [31:0] memw(input logic [31:0] a);
		return {~a[15:0], a[15:0]};
	endfunction

	// offer one instruction, then gather what the unit answers
	task automatic run_op(input logic [4:0] o, d, s, x,
		input logic [17:0] m, input logic p);
		int i;
		instr_op_in = o;
		instr_dst_in = d;
		instr_src_in = s;
		instr_idx_in = x;
		instr_imm_in = m;
		instr_parallel_in = p;
		instr_valid_in = 1'b1;
		{g_len, g_req, g_wb, g_mis, g_und} = 5'h00;
		@(posedge clock_in);
		#1 instr_valid_in = 1'b0;
		for (i = 1; i < 40; i++) begin
			@(posedge clock_in);
			#1;
			if (i == 1) g_len = instr_len32_out;
			if (mem_req_out === 1'b1) begin
				g_req = 1'b1;
				g_addr = mem_addr_out;
			end
			if (wb_valid_out === 1'b1) begin
				g_wb = 1'b1;
				g_sel = wb_sel_out;
				g_data = wb_data_out;
			end
			if (exc_misalign_out === 1'b1) g_mis = 1'b1;
			if (exc_undef_out === 1'b1) g_und = 1'b1;
			if (i > 1 && instr_ready_out === 1'b1) break;
		end
		chk_b(i < 40, 1'b1);
	endtask

	task automatic li(input logic [4:0] o, d, input logic [17:0] m,
		input logic [31:0] e, input logic l);
		run_op(o, d, 5'h00, 5'h00, m, 1'b0);
		chk_b(g_wb && g_sel === d, 1'b1);
		chk_w(g_data, e);
		chk_b(g_len, l);
	endtask

	task automatic setr(input logic [4:0] d, input logic [15:0] v);
		li(ldu_pkg::OP_LDI_Z, d, {2'h0, v}, {16'h0000, v}, 1'b1);
	endtask

	task automatic ld(input logic [4:0] o, d, s, x, input logic [17:0] m,
		input logic [31:0] ea);
		run_op(o, d, s, x, m, 1'b0);
		chk_w(g_addr, ea);
		chk_b(g_wb && g_sel === d, 1'b1);
		chk_w(g_data, memw(ea));
	endtask

	task automatic bad(input logic [4:0] o, d, s, input logic [17:0] m,
		input logic p, em, eu);
		run_op(o, d, s, 5'h00, m, p);
		chk_b(g_mis, em);
		chk_b(g_und, eu);
		chk_b(g_req || g_wb, 1'b0);
	endtask

	task automatic t_imm;
		li(ldu_pkg::OP_LDI_X7, 5'h00, 18'h0_0040, 32'hffff_ffc0, 1'b0);
		li(ldu_pkg::OP_LDI_X7, 5'h09, 18'h0_003f, 32'h0000_003f, 1'b0);
		li(ldu_pkg::OP_LDI_X16, 5'h03, 18'h0_8000, 32'hffff_8000, 1'b1);
		li(ldu_pkg::OP_LDI_X16, 5'h02, 18'h0_7fff, 32'h0000_7fff, 1'b1);
		li(ldu_pkg::OP_LDI_Z, 5'h03, 18'h0_ffff, 32'h0000_ffff, 1'b1);
	endtask

	task automatic t_half;
		setr(5'h0c, 16'h1234);
		li(ldu_pkg::OP_LDI_HI, 5'h0c, 18'h0_bcde, 32'hbcde_1234, 1'b1);
		li(ldu_pkg::OP_LDI_LO, 5'h0c, 18'h0_0010, 32'hbcde_0010, 1'b1);
		ld(ldu_pkg::OP_LD_IND, 5'h00, 5'h0c, 5'h00, 18'h0, 32'hbcde_0010);
	endtask

	task automatic t_acc;
		for (int s = 0; s < 3; s++) begin
			run_op(ldu_pkg::OP_ACC_CLR, 5'(s), 5'h00, 5'h00, 18'h0, 1'b1);
			chk_b(g_wb || g_und, 1'b0);
			chk_b(accum_first_out === 40'h00_0000_0000, 1'b1);
			chk_b(accum_second_out === 40'h00_0000_0000, 1'b1);
		end
		bad(ldu_pkg::OP_ACC_CLR, 5'h03, 5'h00, 18'h0, 1'b0, 1'b0, 1'b1);
	endtask

	task automatic t_ptr;
		setr(5'h09, 16'h0100);
		ld(ldu_pkg::OP_LD_INC, 5'h0a, 5'h09, 5'h00, 18'h0, 32'h0000_0100);
		ld(ldu_pkg::OP_LD_IND, 5'h00, 5'h09, 5'h00, 18'h0, 32'h0000_0104);
		ld(ldu_pkg::OP_LD_DEC, 5'h00, 5'h09, 5'h00, 18'h0, 32'h0000_0104);
		ld(ldu_pkg::OP_LD_IND, 5'h00, 5'h09, 5'h00, 18'h0, 32'h0000_0100);
		ld(ldu_pkg::OP_LD_OFS6, 5'h00, 5'h09, 5'h00, 18'h0_003c, 32'h0000_013c);
		chk_b(g_len, 1'b0);
		ld(ldu_pkg::OP_LD_ADD17, 5'h0a, 5'h09, 5'h00, 18'h1_fffc, 32'h0002_00fc);
		chk_b(g_len, 1'b1);
		ld(ldu_pkg::OP_LD_SUB17, 5'h00, 5'h09, 5'h00, 18'h0_0100, 32'h0000_0000);
		ld(ldu_pkg::OP_LD_IND, 5'h00, 5'h09, 5'h00, 18'h0, 32'h0000_0100);
		setr(5'h0f, 16'h1000);
		ld(ldu_pkg::OP_LD_FP, 5'h0d, 5'h0f, 5'h00, 18'h0_0080, 32'h0000_0f80);
		ld(ldu_pkg::OP_LD_FP, 5'h00, 5'h0f, 5'h00, 18'h0_0004, 32'h0000_0ffc);
	endtask

	task automatic t_fault;
		setr(5'h09, 16'h0102);
		bad(ldu_pkg::OP_LD_IND, 5'h00, 5'h09, 18'h0, 1'b0, 1'b1, 1'b0);
		setr(5'h09, 16'h0200);
		bad(ldu_pkg::OP_LD_INC, 5'h09, 5'h09, 18'h0, 1'b0, 1'b0, 1'b1);
		ld(ldu_pkg::OP_LD_IND, 5'h00, 5'h09, 5'h00, 18'h0, 32'h0000_0200);
		bad(ldu_pkg::OP_LD_ADD17, 5'h00, 5'h09, 18'h0_0004, 1'b1, 1'b0, 1'b1);
		run_op(ldu_pkg::OP_LD_OFS6, 5'h00, 5'h09, 5'h00, 18'h0_0004, 1'b1);
		chk_w(g_addr, 32'h0000_0204);
	endtask

	// slow memory here, so every answer waits on the far side
	task automatic t_index;
		setr(5'h10, 16'h0040);
		setr(5'h14, 16'h0008);
		setr(5'h18, 16'h0040);
		setr(5'h1c, 16'h0010);
		ld(ldu_pkg::OP_LD_IMOD, 5'h01, 5'h10, 5'h14, 18'h0, 32'h0000_0040);
		ld(ldu_pkg::OP_LD_IMOD, 5'h01, 5'h10, 5'h14, 18'h0, 32'h0000_0048);
		ld(ldu_pkg::OP_LD_IMOD, 5'h01, 5'h10, 5'h14, 18'h0, 32'h0000_0040);
		setr(5'h1c, 16'h0000);
		setr(5'h10, 16'h0048);
		ld(ldu_pkg::OP_LD_IMOD, 5'h01, 5'h10, 5'h14, 18'h0, 32'h0000_0048);
		ld(ldu_pkg::OP_LD_IINC, 5'h01, 5'h10, 5'h00, 18'h0, 32'h0000_0050);
		ld(ldu_pkg::OP_LD_IDEC, 5'h01, 5'h10, 5'h00, 18'h0, 32'h0000_0054);
		ld(ldu_pkg::OP_LD_IIND, 5'h01, 5'h10, 5'h00, 18'h0, 32'h0000_0050);
		setr(5'h0a, 16'h0300);
		setr(5'h0b, 16'h0020);
		ld(ldu_pkg::OP_LD_PIDX, 5'h02, 5'h0a, 5'h0b, 18'h0, 32'h0000_0300);
		ld(ldu_pkg::OP_LD_IND, 5'h00, 5'h0a, 5'h00, 18'h0, 32'h0000_0320);
	endtask

	// cuts a hang short well after the expected few hundred cycles
	initial begin
		#200_000;
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		summarize;
	end

	initial begin
		{clock_in, reset_n_in, instr_valid_in, instr_parallel_in} = 4'h0;
		{instr_op_in, instr_dst_in, instr_src_in, instr_idx_in} = 20'h0_0000;
		instr_imm_in = 18'h0_0000;
		lat = 2'h0;
		n_fail = 0;
		tests_run = 0;
		repeat (12) @(posedge clock_in);
		#1 reset_n_in = 1'b1;
		chk_b(instr_ready_out, 1'b1);
		chk_b(wb_valid_out || mem_req_out, 1'b0);
		t_imm;
		t_half;
		t_acc;
		t_ptr;
		t_fault;
		lat = 2'h3;
		t_index;
		summarize;
	end
endmodule
